// ---- shared/tmss_pkg.sv ----
// Constants for the touch matrix scan sequencer.
// Assumes a 10 MHz system clock; all timing counts derive from it.
package tmss_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ          = 10_000_000;
  // Matrix geometry
  localparam int unsigned DRIVE_LINES     = 8;
  localparam int unsigned RECV_LINES      = 2;
  localparam int unsigned KEY_COUNT       = 16;
  localparam int unsigned KEY_W           = 4;
  localparam int unsigned DRV_IDX_W       = 3;
  localparam int unsigned BURST_W         = 8;
  // Conversion counter width, covers the 200..750 count window with headroom
  localparam int unsigned MEAS_W          = 12;
  localparam logic [11:0] MEAS_FULL       = 12'hFFF;
  // Dwell time, least figure, rounded up
  localparam int unsigned DWELL_NS        = 250;
  localparam int unsigned DWELL_CYC_RAW   = (DWELL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned DWELL_CYC       = (DWELL_CYC_RAW < 1) ? 1 : DWELL_CYC_RAW;
  // Low phase of a drive pulse, while the receive line is clamped
  localparam int unsigned CLAMP_CYC       = DWELL_CYC;
  // Scan cycle period
  localparam int unsigned CYCLE_MS        = 16;
  localparam int unsigned CYCLE_CYC       = CYCLE_MS * (CLK_HZ / 1000);
  localparam int unsigned CYC_W           = 18;
  // Sequencer states
  typedef enum logic [2:0] {
    TMSS_IDLE  = 3'b000,
    TMSS_PICK  = 3'b001,
    TMSS_HIGH  = 3'b010,
    TMSS_LOW   = 3'b011,
    TMSS_CLAMP = 3'b100,
    TMSS_RAMP  = 3'b101,
    TMSS_DONE  = 3'b110
  } tmss_state_t;
endpackage : tmss_pkg

// ---- core/tmss_slope_counter.sv ----
// Single-slope conversion timer for one key.
// Assumes the zero-crossing comparator input is synchronous to clk_sys_i.
`timescale 1ns/10ps
module tmss_slope_counter
  import tmss_pkg::*;
#(
  parameter int unsigned WIDTH = MEAS_W
)
(
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  // Control
  input  wire logic             start_i,
  input  wire logic             zero_cross_i,
  // Result
  output logic                  busy_o,
  output logic                  done_o,
  output logic [WIDTH-1:0]      count_o
);
  logic             busy_q;
  logic             done_q;
  logic [WIDTH-1:0] count_q;

  // Count cycles until the ramp crosses zero, or saturate at full scale
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      count_q <= '0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start_i)
      begin
        busy_q  <= 1'b1;
        count_q <= '0;
      end
      else if (busy_q)
      begin
        if (zero_cross_i || (count_q == {WIDTH{1'b1}}))
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        else
          count_q <= count_q + 1'b1;
      end
    end
  end

  assign busy_o  = busy_q;
  assign done_o  = done_q;
  assign count_o = count_q;
endmodule : tmss_slope_counter

// ---- core/tmss_sequencer.sv ----
// Scan sequencer for a 16-key capacitive matrix, eight drive and two receive lines.
// Assumes burst lengths arrive as a flat per-key vector and comparator inputs are synchronous.
`timescale 1ns/10ps
module tmss_sequencer
  import tmss_pkg::*;
#(
  parameter int unsigned CYCLE_CYCLES = CYCLE_CYC
)
(
  // Clock and reset
  input  wire logic                          clk_sys_i,
  input  wire logic                          sys_rst_i,
  // Per-key burst_pulse_count settings, key k at bits [k*8 +: 8]
  input  wire logic [KEY_COUNT*BURST_W-1:0]  burst_pulse_count_i,
  // Zero-crossing comparator per receive line
  input  wire logic [RECV_LINES-1:0]         zero_cross_i,
  // Matrix pins
  output logic [DRIVE_LINES-1:0]             drive_o,
  output logic [RECV_LINES-1:0]              recv_clamp_o,
  // Measurement result
  output logic                               result_valid_o,
  output logic [KEY_W-1:0]                   result_key_o,
  output logic [MEAS_W-1:0]                  result_count_o,
  // Status
  output logic                               asleep_o,
  output logic                               cycle_start_o
);
  tmss_state_t         state_q;
  logic [CYC_W-1:0]    cyc_cnt_q;
  logic                cycle_tick;
  logic [KEY_W-1:0]    key_q;
  logic [BURST_W-1:0]  pulses_q;
  logic [7:0]          phase_q;
  logic [BURST_W-1:0]  cur_len;
  logic                last_key;
  logic                conv_start;
  logic                conv_done;
  logic [MEAS_W-1:0]   conv_count;
  logic [DRIVE_LINES-1:0] drive_q;
  logic [RECV_LINES-1:0]  clamp_q;
  logic                valid_q;
  logic [KEY_W-1:0]    rkey_q;
  logic [MEAS_W-1:0]   rcount_q;
  logic                sleep_q;
  logic                cstart_q;
  logic                recv_idx;

  // Receive index is the key's top bit, drive index its low three bits
  assign recv_idx   = key_q[KEY_W-1];
  assign cur_len    = burst_pulse_count_i[key_q*BURST_W +: BURST_W];
  assign last_key   = (key_q == 4'hF);
  assign cycle_tick = (cyc_cnt_q == CYC_W'(CYCLE_CYCLES - 1));
  assign conv_start = (state_q == TMSS_CLAMP);

  // Free-running scan cycle timer
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || cycle_tick)
      cyc_cnt_q <= '0;
    else
      cyc_cnt_q <= cyc_cnt_q + 1'b1;
  end

  // Key stepping and burst state machine
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      state_q  <= TMSS_IDLE;
      key_q    <= '0;
      pulses_q <= '0;
      phase_q  <= '0;
    end
    else
    begin
      case (state_q)
        TMSS_IDLE:
          if (cycle_tick)
          begin
            key_q   <= '0;
            state_q <= TMSS_PICK;
          end
        TMSS_PICK:
          if (cur_len == 8'h00)
          begin
            if (last_key)
              state_q <= TMSS_IDLE;
            else
              key_q <= key_q + 1'b1;
          end
          else
          begin
            pulses_q <= cur_len;
            phase_q  <= '0;
            state_q  <= TMSS_HIGH;
          end
        TMSS_HIGH:
          if (phase_q == 8'(DWELL_CYC - 1))
          begin
            phase_q  <= '0;
            pulses_q <= pulses_q - 1'b1;
            state_q  <= TMSS_LOW;
          end
          else
            phase_q <= phase_q + 1'b1;
        TMSS_LOW:
          if (phase_q == 8'(CLAMP_CYC - 1))
          begin
            phase_q <= '0;
            state_q <= (pulses_q == 8'h00) ? TMSS_CLAMP : TMSS_HIGH;
          end
          else
            phase_q <= phase_q + 1'b1;
        TMSS_CLAMP:
          state_q <= TMSS_RAMP;
        TMSS_RAMP:
          if (conv_done)
            state_q <= TMSS_DONE;
        TMSS_DONE:
          if (last_key)
            state_q <= TMSS_IDLE;
          else
          begin
            key_q   <= key_q + 1'b1;
            state_q <= TMSS_PICK;
          end
        default:
          state_q <= TMSS_IDLE;
      endcase
    end
  end

  // Drive pin high only during the dwell phase of the active line
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      drive_q <= '0;
    else if ((state_q == TMSS_PICK) && (cur_len != 8'h00))
      drive_q <= DRIVE_LINES'(1) << key_q[DRV_IDX_W-1:0];
    else if ((state_q == TMSS_LOW) && (phase_q == 8'(CLAMP_CYC - 1)) && (pulses_q != 8'h00))
      drive_q <= DRIVE_LINES'(1) << key_q[DRV_IDX_W-1:0];
    else if ((state_q == TMSS_HIGH) && (phase_q == 8'(DWELL_CYC - 1)))
      drive_q <= '0;
    else if (state_q == TMSS_IDLE)
      drive_q <= '0;
  end

  // Clamp held through each low phase and during the post-burst clamp
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      clamp_q <= '0;
    else if ((state_q == TMSS_HIGH) && (phase_q == 8'(DWELL_CYC - 1)))
      clamp_q <= RECV_LINES'(1) << recv_idx;
    else if ((state_q == TMSS_LOW) && (phase_q == 8'(CLAMP_CYC - 1)))
      clamp_q <= (pulses_q == 8'h00) ? (RECV_LINES'(1) << recv_idx) : '0;
    else if (state_q == TMSS_CLAMP)
      clamp_q <= '0;                                               // Release so the ramp can run
  end

  // Ramp timer; saturation keeps a dead electrode from stalling the scan
  tmss_slope_counter #(
    .WIDTH        (MEAS_W)
  ) u_slope (
    .clk_sys_i    (clk_sys_i),
    .sys_rst_i    (sys_rst_i),
    .start_i      (conv_start),
    .zero_cross_i (zero_cross_i[recv_idx]),
    .busy_o       (),
    .done_o       (conv_done),
    .count_o      (conv_count)
  );

  // Result registers
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      valid_q  <= 1'b0;
      rkey_q   <= '0;
      rcount_q <= '0;
    end
    else
    begin
      valid_q <= conv_done;
      if (conv_done)
      begin
        rkey_q   <= key_q;
        rcount_q <= conv_count;
      end
    end
  end

  // Sleep and cycle status
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      sleep_q  <= 1'b1;
      cstart_q <= 1'b0;
    end
    else
    begin
      sleep_q  <= (state_q == TMSS_IDLE) && !cycle_tick;
      cstart_q <= cycle_tick;
    end
  end

  assign drive_o        = drive_q;
  assign recv_clamp_o   = clamp_q;
  assign result_valid_o = valid_q;
  assign result_key_o   = rkey_q;
  assign result_count_o = rcount_q;
  assign asleep_o       = sleep_q;
  assign cycle_start_o  = cstart_q;
endmodule : tmss_sequencer

// ---- sim/tmss_seq_sva.sv ----
// Checker on the scan sequencer pins.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module tmss_seq_sva
  import tmss_pkg::*;
#(
  parameter int unsigned CYCLE_CYCLES = CYCLE_CYC
)
(
  // Clock and reset
  input wire logic                   clk_sys_i,
  input wire logic                   sys_rst_i,
  // Watched outputs
  input wire logic [DRIVE_LINES-1:0] drive_o,
  input wire logic [RECV_LINES-1:0]  recv_clamp_o,
  input wire logic                   result_valid_o,
  input wire logic                   asleep_o,
  input wire logic                   cycle_start_o
);
  logic [17:0] gap_q;
  logic        seen_q;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // Cycles since the last scan start; the first gap is skipped
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || cycle_start_o)
      gap_q <= 18'h00001;
    else
      gap_q <= gap_q + 18'h00001;
  end
  // Marks that one scan start has been seen
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      seen_q <= 1'b0;
    else if (cycle_start_o)
      seen_q <= 1'b1;
  end
  one_drive_a: assert property ($onehot0(drive_o)) else $error("two drive lines high");
  dwell_len_a: assert property ($rose(|drive_o) |-> (|drive_o) [*3] ##1 !(|drive_o))
    else $error("dwell phase not three cycles");
  fall_clamp_a: assert property ($fell(|drive_o) |-> |recv_clamp_o) else $error("no clamp on drive fall");
  clamp_apart_a: assert property ((|drive_o) |-> !(|recv_clamp_o)) else $error("clamp during dwell");
  burst_quiet_a: assert property (result_valid_o |-> drive_o == 8'h00) else $error("result during burst");
  valid_pulse_a: assert property (result_valid_o |=> !result_valid_o) else $error("result pulse too long");
  sleep_quiet_a: assert property (asleep_o |-> drive_o == 8'h00) else $error("drive while asleep");
  cycle_gap_a: assert property (cycle_start_o && seen_q |-> gap_q == CYCLE_CYCLES)
    else $error("scan period wrong");
endmodule : tmss_seq_sva
bind tmss_sequencer tmss_seq_sva #(.CYCLE_CYCLES(CYCLE_CYCLES)) sva_u (.clk_sys_i(clk_sys_i),
  .sys_rst_i(sys_rst_i), .drive_o(drive_o), .recv_clamp_o(recv_clamp_o), .result_valid_o(result_valid_o),
  .asleep_o(asleep_o), .cycle_start_o(cycle_start_o));

// ---- sim/tmss_matrix_model.sv ----
// Behavioural key matrix with sample capacitors and ramp comparators.
// Assumes drive and clamp pins are registered on clk_sys_i.
`timescale 1ns/10ps
module tmss_matrix_model
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  // Matrix pins and fault control
  input  wire logic [7:0] drive_i,
  input  wire logic [1:0] clamp_i,
  input  wire logic       stuck_i,
  // Comparators
  output logic [1:0]      zero_cross_o
);
  logic        drv_q;
  logic [1:0]  clp_q;
  logic        ramp_q;
  logic        line_q;
  logic [11:0] cnt_q;
  logic [7:0]  pls_q;
  logic        done;
  // Charge grows with pulses, so the ramp takes longer
  assign done = ramp_q && (cnt_q >= 12'h0C8 + {1'b0, pls_q, 3'h0});
  assign zero_cross_o = (done && !stuck_i) ? {line_q, !line_q} : 2'h0;
  // Pulse count, clamp edge and ramp timer
  always_ff @(posedge clk_sys_i)
  begin
    drv_q <= |drive_i;
    clp_q <= clamp_i;
    if (sys_rst_i)
    begin
      ramp_q <= 1'b0;
      cnt_q <= 12'h000;
      pls_q <= 8'h00;
    end
    else if ((|drive_i) && !drv_q)
    begin
      pls_q <= done ? 8'h01 : pls_q + 8'h01;
      ramp_q <= 1'b0;
    end
    else if (|(clp_q & ~clamp_i))
    begin
      ramp_q <= 1'b1;
      cnt_q <= 12'h000;
      line_q <= clp_q[1];
    end
    else if (ramp_q && cnt_q != 12'hFFF)
      cnt_q <= cnt_q + 12'h001;
  end
endmodule : tmss_matrix_model

// ---- sim/touch_matrix_scan_sequencer_tb.sv ----
// Self-checking bench for the scan sequencer.
// Assumes a shortened scan period and the matrix model as far side.
`timescale 1ns/10ps
module touch_matrix_scan_sequencer_tb;
  import tmss_pkg::*;
  localparam int CYC = 8000;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic stuck = 1'b0;
  logic [127:0] bpc = '0;
  logic [1:0] zc;
  logic [7:0] drv;
  logic [1:0] clp;
  logic rv, slp, cs, drv_d;
  logic [3:0] rkey;
  logic [11:0] rcnt;
  logic [3:0] rk[$];
  logic [11:0] rc[$];
  int rp[$];
  logic [7:0] rd[$];
  logic [1:0] rl[$];
  logic [7:0] dseen = '0;
  logic [1:0] cseen = '0;
  int pc, n_fail, checks;
  tmss_sequencer #(.CYCLE_CYCLES(CYC)) dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .burst_pulse_count_i(bpc), .zero_cross_i(zc), .drive_o(drv), .recv_clamp_o(clp), .result_valid_o(rv),
    .result_key_o(rkey), .result_count_o(rcnt), .asleep_o(slp), .cycle_start_o(cs));
  tmss_matrix_model mdl_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .drive_i(drv), .clamp_i(clp),
    .stuck_i(stuck), .zero_cross_o(zc));
  initial forever #50 clk_sys_i = !clk_sys_i;
  // Log results with the pulses, drive lines and clamp lines seen since the previous one
  always @(posedge clk_sys_i)
  begin
    drv_d <= |drv;
    if (rv === 1'b1)
    begin
      rk.push_back(rkey);
      rc.push_back(rcnt);
      rp.push_back(pc);
      rd.push_back(dseen);
      rl.push_back(cseen);
      pc = 0;
      dseen = '0;
      cseen = '0;
    end
    else
    begin
      if ((|drv) === 1'b1 && !drv_d)
        pc = pc + 1;
      if ((|drv) === 1'b1)
        dseen = dseen | drv;
      if ((|clp) === 1'b1)
        cseen = cseen | clp;
    end
  end
  task automatic chk(logic [31:0] got, logic [31:0] exp, string msg);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // Waits for the next scan start, bounded, returning cycles spent
  task automatic wait_start(output int t);
    for (t = 1; t <= 2 * CYC; t++)
    begin
      @(posedge clk_sys_i);
      #1;
      if (cs === 1'b1)
        return;
    end
    n_fail++;
    print_verdict();
  endtask : wait_start
  // Burst setting per key: every third key disabled, one long burst
  function automatic logic [7:0] key_len(int k);
    return (k == 7) ? 8'hFF : ((k % 3 == 0) ? 8'h00 : 8'(k % 4 + 1));
  endfunction : key_len
  // Mixed lengths: order, skipping, pulse counts, lines, ramp counts, period
  task automatic scan_mix();
    int k, n, t, e;
    logic [127:0] cfg;
    cfg = '0;
    for (k = 0; k < 16; k++)
      cfg[k*8+:8] = key_len(k);
    @(posedge clk_sys_i);
    bpc <= cfg;
    wait_start(t);
    rk = {};
    rc = {};
    rp = {};
    rd = {};
    rl = {};
    wait_start(t);
    chk(t, CYC, "period");
    n = 0;
    for (k = 0; k < 16; k++)
      if (key_len(k) != 0 && n < rk.size())
      begin
        e = 200 + 8 * key_len(k);
        chk(rk[n], k, "key order");
        chk(rp[n], key_len(k), "pulses");
        chk(rd[n], 8'h01 << (k % 8), "drive line");
        chk(rl[n], 2'h1 << (k / 8), "receive line");
        chk(rc[n] >= e - 2 && rc[n] <= e + 3, 1, "ramp count");
        n++;
      end
    chk(rk.size(), 10, "result total");
    // One extra pulse must move the count by at least the smallest touch swing
    chk(rc.size() > 2 && rc[0] >= rc[2] + 8, 1, "touch swing");
  endtask : scan_mix
  // No zero crossing on one lone key: full scale, scan still ends
  task automatic scan_sat();
    int t;
    @(posedge clk_sys_i);
    bpc <= {48'h0, 8'h02, 72'h0}; // Key 9 only, two pulses
    stuck <= 1'b1;
    wait_start(t);
    rk = {};
    rc = {};
    wait_start(t);
    chk(rk.size(), 1, "sat total");
    chk(rk[0], 9, "sat key");
    chk(rc[0], 12'hFFF, "sat count");
    chk(slp, 0, "awake at start");
  endtask : scan_sat
  initial
  begin
    n_fail = 0;
    checks = 0;
    pc = 0;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    scan_mix();
    scan_sat();
    print_verdict();
  end
endmodule : touch_matrix_scan_sequencer_tb
